// file: pao_peer.sv
`timescale 1ns/100ps
`default_nettype none
module pao_peer (
  input  wire logic                 clk,    // system clock
  input  wire logic                 rst_b,  // async reset, active low
  input  wire logic                 osc_in, // oscillator output seen
  output var  pao_pkg::pao_src_in_t src,    // cell and oscillator levels
  output var  int                   edges   // rising edges of osc_in
);
  import pao_pkg::*;
  logic [4:0] cnt_reg;
  logic       last_reg;
  // binary weighted rates: cells rise every 32, 16, 8, 4 cycles, oscillator every 2
  assign src = pao_src_in_t'(cnt_reg);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg  <= 5'h00;
      last_reg <= 1'b0;
      edges    <= 0;
    end else begin
      cnt_reg  <= cnt_reg + 5'h01;
      last_reg <= osc_in;
      edges    <= edges + int'(osc_in && !last_reg);
    end
  end
endmodule : pao_peer
`default_nettype wire

// file: pao_pkg.sv
// Contract
// RL1: each selected input clock rising edge, accumulator becomes accumulator plus active increment.
// RL2: accumulator is twenty bits wide.
// RL3: adder carry out is the raw output pulse.
// RL4: every carry overflow raises an interrupt request.
// RL5: raw pulse optionally stretched or toggled, then routed internally and to pin.
// RL6: three-bit source select picks oscillator, system clock or four logic cells.
// RL7: accumulator readable and writable through low, high, upper byte registers.
// RL8: increment stored in low, high, upper byte registers.
// RL9: software writes upper and high before low while enabled.
// RL10: while enabled, low write loads buffers on second input clock edge.
// RL11: increment registers are double buffered.
// RL12: while disabled, buffers load right after any increment write.
// RL13: internal increment buffers are hidden from software.
// RL14: adder is combinational; sum captured only at input clock edges.
// RL15: overflow keeps the wrapped remainder modulo two to the twentieth.
// RL16: software accumulator write beats the adder on the same edge.
package pao_pkg;

  localparam int unsigned ACC_W = 20;
  localparam int unsigned ADDR_W = 4;

  localparam logic [3:0] OFS_CTRL      = 4'h0;
  localparam logic [3:0] OFS_CLK_CFG   = 4'h1;
  localparam logic [3:0] OFS_ACC_LOW   = 4'h2;
  localparam logic [3:0] OFS_ACC_HIGH  = 4'h3;
  localparam logic [3:0] OFS_ACC_UPPER = 4'h4;
  localparam logic [3:0] OFS_INC_LOW   = 4'h5;
  localparam logic [3:0] OFS_INC_HIGH  = 4'h6;
  localparam logic [3:0] OFS_INC_UPPER = 4'h7;
  localparam logic [3:0] OFS_IRQ_STAT  = 4'h8;
  localparam logic [3:0] OFS_IRQ_EN    = 4'h9;
  localparam logic [3:0] OFS_IRQ_CLR   = 4'ha;

  // control register fields
  localparam int unsigned CTRL_EN_BIT  = 0;
  localparam int unsigned CTRL_PFM_BIT = 1;
  localparam int unsigned CTRL_OE_BIT  = 2;
  localparam int unsigned CTRL_POL_BIT = 3;
  // clock config fields
  localparam int unsigned CLK_SEL_LSB = 0;
  localparam int unsigned PW_LSB      = 4;

  localparam logic [7:0]       CTRL_RST   = 8'h00;
  localparam logic [7:0]       CLK_RST    = 8'h00;
  localparam logic [ACC_W-1:0] ACC_RST    = 20'h00000;
  localparam logic [ACC_W-1:0] INC_RST    = 20'h00001;
  localparam logic [2:0]       PW_CNT_RST = 3'h0;

  typedef enum logic [2:0] {
    PAO_SRC_HFOSC = 3'h0,
    PAO_SRC_SYS   = 3'h1,
    PAO_SRC_LC1   = 3'h2,
    PAO_SRC_LC2   = 3'h3,
    PAO_SRC_LC3   = 3'h4,
    PAO_SRC_LC4   = 3'h5
  } pao_src_t;

  typedef enum logic [2:0] {
    PAO_LD_IDLE  = 3'b001,
    PAO_LD_EDGE1 = 3'b010,
    PAO_LD_EDGE2 = 3'b100
  } pao_ld_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
    logic              wr;
    logic              rd;
  } pao_bus_req_t;

  typedef struct packed {
    logic              logic_cell_1_output;
    logic              logic_cell_2_output;
    logic              logic_cell_3_output;
    logic              logic_cell_4_output;
    logic              internal_high_freq_osc;
  } pao_src_in_t;

  typedef struct packed {
    logic [7:0]       ctrl;
    logic [7:0]       clk_cfg;
    logic [ACC_W-1:0] acc;
    logic [ACC_W-1:0] inc_front;
    logic [ACC_W-1:0] inc_buf;
    pao_ld_t          ld;
    logic [2:0]       src_q;
    logic             overflow_pulse;
    logic             toggle_q;
    logic [2:0]       pw_cnt;
    logic             irq_stat;
    logic             irq_en;
    logic [7:0]       rdata;
  } pao_state_t;

endpackage : pao_pkg

// file: pao_props.sv
`timescale 1ns/100ps
`default_nettype none
module pao_props (
  input wire logic                  clk,          // system clock
  input wire logic                  rst_b,        // async reset
  input wire pao_pkg::pao_bus_req_t bus_req,      // register request
  input wire logic [7:0]            bus_rdata,    // read data
  input wire logic                  osc_out,      // modified output
  input wire logic                  osc_pin,      // pin level
  input wire logic                  osc_pin_oe,   // pin enable
  input wire logic                  overflow_raw, // raw carry
  input wire logic                  irq           // interrupt
);
  import pao_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_pin_follow: assert property (osc_pin == osc_out) else $error("pin differs");
  chk_rdata_idle: assert property (!$past(bus_req.rd) |-> bus_rdata == 8'h00)
    else $error("read data without read");
  chk_irq_cause: assert property ($rose(irq) |-> overflow_raw || $past(bus_req.wr))
    else $error("interrupt without overflow");
  chk_unmapped_zero: assert property (bus_req.rd && bus_req.addr > OFS_IRQ_EN
    |=> bus_rdata == 8'h00) else $error("unmapped read not zero");
  chk_upper_width: assert property (bus_req.rd && (bus_req.addr == OFS_ACC_UPPER
    || bus_req.addr == OFS_INC_UPPER) |=> bus_rdata[7:4] == 4'h0) else $error("upper bits set");
  chk_irq_clear: assert property (bus_req.wr && bus_req.addr == OFS_IRQ_CLR
    && bus_req.wdata[0] |=> !irq || overflow_raw) else $error("interrupt not cleared");
  chk_off_quiet: assert property (bus_req.wr && bus_req.addr == OFS_CTRL
    && !bus_req.wdata[CTRL_EN_BIT] |=> ##1 !overflow_raw) else $error("tick while disabled");
  chk_pin_enable: assert property (bus_req.wr && bus_req.addr == OFS_CTRL
    |=> osc_pin_oe == $past(bus_req.wdata[CTRL_OE_BIT])) else $error("pin enable wrong");
  cov_overflow: cover property (overflow_raw);
  cov_irq: cover property (irq);
  cov_acc_read: cover property (bus_req.rd && bus_req.addr == OFS_ACC_LOW);
endmodule : pao_props
`default_nettype wire

// file: pao_top.sv
`timescale 1ns/100ps
`default_nettype none
module pao_top (
  input  wire logic                  clk,          // 100 MHz system clock
  input  wire logic                  rst_b,        // async reset, active low
  input  wire pao_pkg::pao_bus_req_t bus_req,      // register request
  output logic [7:0]                 bus_rdata,    // read data, cycle after read
  input  wire pao_pkg::pao_src_in_t  src_in,       // candidate input clocks
  output logic                       osc_out,      // modified output to peripherals
  output logic                       osc_pin,      // pin level
  output logic                       osc_pin_oe,   // pin output enable
  output logic                       overflow_raw, // raw carry pulse
  output logic                       irq           // level interrupt
);
  import pao_pkg::*;

  pao_state_t s_reg;
  pao_state_t s_next;

  logic             src_lvl;
  logic             tick;
  logic [ACC_W:0]   sum;
  logic             enabled;
  logic             wr_acc;
  logic [ACC_W-1:0] acc_wr;
  logic [ACC_W-1:0] inc_wr;

  function automatic logic [ACC_W-1:0] put_byte(
    input logic [ACC_W-1:0] v,
    input logic [1:0]       idx,
    input logic [7:0]       b
  );
    logic [ACC_W-1:0] r;
    r = v;
    unique case (idx)
      2'd0: r[7:0] = b;
      2'd1: r[15:8] = b;
      default: r[19:16] = b[3:0];
    endcase
    return r;
  endfunction : put_byte

  function automatic logic [7:0] get_byte(
    input logic [ACC_W-1:0] v,
    input logic [1:0]       idx
  );
    logic [7:0] r;
    r = 8'h00;
    unique case (idx)
      2'd0: r = v[7:0];
      2'd1: r = v[15:8];
      default: r = {4'h0, v[19:16]};
    endcase
    return r;
  endfunction : get_byte

  // source mux; sys clock source ticks every cycle
  always_comb begin
    unique case (s_reg.clk_cfg[CLK_SEL_LSB +: 3]) // RL6
      PAO_SRC_HFOSC: src_lvl = src_in.internal_high_freq_osc;
      PAO_SRC_LC1:   src_lvl = src_in.logic_cell_1_output;
      PAO_SRC_LC2:   src_lvl = src_in.logic_cell_2_output;
      PAO_SRC_LC3:   src_lvl = src_in.logic_cell_3_output;
      PAO_SRC_LC4:   src_lvl = src_in.logic_cell_4_output;
      default:       src_lvl = 1'b1;
    endcase
  end

  assign enabled = s_reg.ctrl[CTRL_EN_BIT];
  // rising edge of the selected source, as a one-cycle enable
  assign tick = enabled && ((s_reg.clk_cfg[CLK_SEL_LSB +: 3] == PAO_SRC_SYS)
                || (src_lvl && !s_reg.src_q[0]));
  // adder always settles; only tick captures it
  assign sum = {1'b0, s_reg.acc} + {1'b0, s_reg.inc_buf}; // RL14

  assign wr_acc = bus_req.wr && (bus_req.addr == OFS_ACC_LOW
                  || bus_req.addr == OFS_ACC_HIGH || bus_req.addr == OFS_ACC_UPPER);
  assign acc_wr = put_byte(s_reg.acc, 2'(bus_req.addr - OFS_ACC_LOW), bus_req.wdata);
  assign inc_wr = put_byte(s_reg.inc_front, 2'(bus_req.addr - OFS_INC_LOW), bus_req.wdata);

  always_comb begin
    s_next = s_reg;
    s_next.src_q = {s_reg.src_q[1:0], src_lvl};
    s_next.overflow_pulse = 1'b0;

    if (tick) begin
      s_next.acc = sum[ACC_W-1:0]; // RL1 RL2 RL15
      if (sum[ACC_W]) begin
        s_next.overflow_pulse = 1'b1; // RL3
        s_next.toggle_q = !s_reg.toggle_q;
        s_next.pw_cnt = s_reg.clk_cfg[PW_LSB +: 3];
      end
    end
    if (s_reg.pw_cnt != PW_CNT_RST && tick && !sum[ACC_W]) begin
      s_next.pw_cnt = s_reg.pw_cnt - 3'h1;
    end

    // sticky flag; set beats clear
    if (bus_req.wr && bus_req.addr == OFS_IRQ_CLR && bus_req.wdata[0]) begin
      s_next.irq_stat = 1'b0;
    end
    if (tick && sum[ACC_W]) begin
      s_next.irq_stat = 1'b1; // RL4
    end

    // buffer load sequencer, counts input clock edges
    unique case (s_reg.ld)
      PAO_LD_IDLE: ;
      PAO_LD_EDGE1: if (tick) s_next.ld = PAO_LD_EDGE2;
      PAO_LD_EDGE2: if (tick) begin
        s_next.inc_buf = s_reg.inc_front; // RL10 RL11
        s_next.ld = PAO_LD_IDLE;
      end
      default: s_next.ld = PAO_LD_IDLE;
    endcase
    if (!enabled) begin
      s_next.inc_buf = s_reg.inc_front; // RL12
      s_next.ld = PAO_LD_IDLE;
    end

    if (bus_req.wr) begin
      unique case (bus_req.addr)
        OFS_CTRL:     s_next.ctrl = bus_req.wdata;
        OFS_CLK_CFG:  s_next.clk_cfg = bus_req.wdata;
        OFS_IRQ_EN:   s_next.irq_en = bus_req.wdata[0];
        OFS_INC_LOW:  begin
          s_next.inc_front = inc_wr; // RL8
          // restart count; the edge of this cycle is not the first
          if (enabled) s_next.ld = PAO_LD_EDGE1; // RL10
        end
        OFS_INC_HIGH, OFS_INC_UPPER: s_next.inc_front = inc_wr; // RL8
        default: ;
      endcase
    end
    if (wr_acc) begin
      s_next.acc = acc_wr; // RL7 RL16
    end

    s_next.rdata = 8'h00;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        OFS_CTRL:     s_next.rdata = s_reg.ctrl;
        OFS_CLK_CFG:  s_next.rdata = s_reg.clk_cfg;
        OFS_ACC_LOW, OFS_ACC_HIGH, OFS_ACC_UPPER:
          s_next.rdata = get_byte(s_reg.acc, 2'(bus_req.addr - OFS_ACC_LOW)); // RL7
        // only the front registers read back, buffer is hidden
        OFS_INC_LOW, OFS_INC_HIGH, OFS_INC_UPPER:
          s_next.rdata = get_byte(s_reg.inc_front, 2'(bus_req.addr - OFS_INC_LOW)); // RL13
        OFS_IRQ_STAT: s_next.rdata = {7'h00, s_reg.irq_stat};
        OFS_IRQ_EN:   s_next.rdata = {7'h00, s_reg.irq_en};
        default:      s_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '{ctrl: CTRL_RST, clk_cfg: CLK_RST, acc: ACC_RST, inc_front: INC_RST,
                 inc_buf: INC_RST, ld: PAO_LD_IDLE, src_q: 3'h0, overflow_pulse: 1'b0,
                 toggle_q: 1'b0, pw_cnt: PW_CNT_RST, irq_stat: 1'b0, irq_en: 1'b0,
                 rdata: 8'h00};
    end else begin
      s_reg <= s_next;
    end
  end

  logic mod_out;
  // pulse mode stretches over pw_cnt extra input clock edges
  always_comb begin
    if (s_reg.ctrl[CTRL_PFM_BIT]) begin
      mod_out = s_reg.overflow_pulse || (s_reg.pw_cnt != PW_CNT_RST); // RL5
    end else begin
      mod_out = s_reg.toggle_q; // RL5
    end
  end

  assign overflow_raw = s_reg.overflow_pulse; // RL3
  assign osc_out      = (mod_out ^ s_reg.ctrl[CTRL_POL_BIT]) && enabled;
  assign osc_pin      = osc_out;
  assign osc_pin_oe   = s_reg.ctrl[CTRL_OE_BIT];
  assign bus_rdata    = s_reg.rdata;
  assign irq          = s_reg.irq_stat && s_reg.irq_en;

endmodule : pao_top
`default_nettype wire

// file: tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import pao_pkg::*;
  logic         clk, rst_b, osc_out, osc_pin, osc_pin_oe, overflow_raw, irq;
  pao_bus_req_t bus_req;
  logic [7:0]   bus_rdata;
  pao_src_in_t  src_in;
  logic [31:0]  seed;
  int           mismatches, samples_checked, ovf_n, edges;
  pao_top dut_u (.clk(clk), .rst_b(rst_b), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .src_in(src_in), .osc_out(osc_out), .osc_pin(osc_pin), .osc_pin_oe(osc_pin_oe),
    .overflow_raw(overflow_raw), .irq(irq));
  pao_peer peer_u (.clk(clk), .rst_b(rst_b), .osc_in(osc_out), .src(src_in), .edges(edges));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) ovf_n <= ovf_n + int'(overflow_raw === 1'b1);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic int exp_ovf(input int per, input int n);
    return n / (per * 4); // quarter-turn increment
  endfunction : exp_ovf
  task automatic cmp(input string n, input logic [19:0] e, input logic [19:0] s, input int tol);
    samples_checked++;
    if (tol == 0 ? s !== e : (s > e + 20'(tol) || s + 20'(tol) < e)) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : cmp
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
  endtask : wr
  task automatic nop(input int n);
    bus_req <= '0;
    repeat (n) @(posedge clk);
    #1;
  endtask : nop
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req <= '0;
    #1;
    cmp("rdata", 20'(e), 20'(bus_rdata), 0);
  endtask : rdc
  task automatic w20(input logic [3:0] b, input logic [19:0] v);
    wr(b + 4'h2, {4'h0, v[19:16]});
    wr(b + 4'h1, v[15:8]);
    wr(b, v[7:0]);
  endtask : w20
  task automatic r20(input logic [3:0] b, input logic [19:0] v);
    rdc(b, v[7:0]);
    rdc(b + 4'h1, v[15:8]);
    rdc(b + 4'h2, {4'h0, v[19:16]});
  endtask : r20
  task automatic span(input logic [7:0] c, input logic [2:0] s, input int per);
    int o, e;
    wr(OFS_CLK_CFG, {5'h00, s});
    o = ovf_n;
    e = edges;
    wr(OFS_CTRL, c);
    nop(256);
    wr(OFS_CTRL, 8'h00);
    nop(2);
    cmp("overflows", 20'(exp_ovf(per, 256)), 20'(ovf_n - o), 1);
    cmp("out_edges", 20'(c[1] ? ovf_n - o : (ovf_n - o) / 2), 20'(edges - e), 1);
  endtask : span
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    complete_run();
  end
  initial begin
    bus_req = '0;
    rst_b = 1'b0;
    seed = 32'h2406;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    r20(OFS_INC_LOW, INC_RST);
    r20(OFS_ACC_LOW, ACC_RST);
    rdc(4'hf, 8'h00);
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      w20(OFS_ACC_LOW, seed[19:0]);
      r20(OFS_ACC_LOW, seed[19:0]);
      w20(OFS_INC_LOW, seed[31:12]);
      r20(OFS_INC_LOW, seed[31:12]);
    end
    w20(OFS_ACC_LOW, 20'hfffff);
    w20(OFS_INC_LOW, 20'h00002);
    wr(OFS_IRQ_EN, 8'h01);
    wr(OFS_CLK_CFG, {5'h00, PAO_SRC_SYS});
    // one enabled cycle gives exactly one tick
    wr(OFS_CTRL, 8'h01);
    wr(OFS_CTRL, 8'h00);
    nop(1);
    r20(OFS_ACC_LOW, 20'h00001);
    cmp("irq", 20'h00001, 20'(irq), 0);
    wr(OFS_IRQ_EN, 8'h00);
    wr(OFS_IRQ_STAT, 8'h00);
    nop(1);
    cmp("irq_masked", 20'h00000, 20'(irq), 0);
    rdc(OFS_IRQ_STAT, 8'h01);
    wr(OFS_IRQ_CLR, 8'h01);
    wr(OFS_IRQ_EN, 8'h01);
    rdc(OFS_IRQ_STAT, 8'h00);
    w20(OFS_INC_LOW, 20'h00001);
    w20(OFS_ACC_LOW, 20'h00000);
    // ticks in seven cycles: five at the old step, two at the new
    wr(OFS_CTRL, 8'h01);
    w20(OFS_INC_LOW, 20'h80000);
    nop(3);
    wr(OFS_CTRL, 8'h00);
    nop(1);
    r20(OFS_ACC_LOW, 20'h00005);
    r20(OFS_INC_LOW, 20'h80000);
    w20(OFS_INC_LOW, 20'h40000);
    span(8'h07, PAO_SRC_SYS, 1);
    span(8'h07, PAO_SRC_HFOSC, 2);
    span(8'h07, PAO_SRC_LC1, 32);
    span(8'h07, PAO_SRC_LC2, 16);
    span(8'h07, PAO_SRC_LC3, 8);
    span(8'h07, PAO_SRC_LC4, 4);
    span(8'h05, PAO_SRC_SYS, 1);
    // stretch longer than the overflow period keeps the output high
    begin : stretch_blk
      int e0;
      wr(OFS_CLK_CFG, 8'h71);
      e0 = edges;
      wr(OFS_CTRL, 8'h03);
      nop(64);
      cmp("stretch_level", 20'h00001, 20'(osc_out), 0);
      cmp("stretch_edges", 20'h00001, 20'(edges - e0), 0);
    end
    wr(OFS_CTRL, 8'h00);
    w20(OFS_INC_LOW, 20'h00010);
    w20(OFS_ACC_LOW, 20'h00000);
    // two ticks, the first lands with a low byte write and must lose
    wr(OFS_CTRL, 8'h01);
    wr(OFS_ACC_LOW, 8'h00);
    wr(OFS_CTRL, 8'h00);
    nop(1);
    r20(OFS_ACC_LOW, 20'h00010);
    complete_run();
  end
endmodule : tb
bind pao_top pao_props chk_u (.clk(clk), .rst_b(rst_b), .bus_req(bus_req),
  .bus_rdata(bus_rdata), .osc_out(osc_out), .osc_pin(osc_pin), .osc_pin_oe(osc_pin_oe),
  .overflow_raw(overflow_raw), .irq(irq));
`default_nettype wire
